//--- hw/apc_map.svh
/*
 * Register indices, reset values, field codes and timing figures for the
 * auxiliary pin block. Assumes inclusion by bare name from the design files.
 */
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// Register indices; byte address is four times the index.
`define APC_IDX_FORCE_WP   8'hC5
`define APC_IDX_RING_SEL   8'hC6
`define APC_IDX_PIN_A      8'hE0
`define APC_IDX_PIN_B      8'hE1
`define APC_IDX_PIN_C      8'hE2
`define APC_IDX_EVT_STAT   8'hF0
`define APC_IDX_PIN_DATA   8'hF1

// Reset values.
`define APC_RST_FORCE_WP   8'h00
`define APC_RST_RING_SEL   8'h00
`define APC_RST_PIN_CFG    8'h01
`define APC_RST_PIN_DATA   3'h0

// Implemented-bit masks; reserved bits store nothing and read zero.
`define APC_MASK_FORCE_WP  8'h01
`define APC_MASK_RING_SEL  8'h07
`define APC_MASK_PIN_A     8'h8F
`define APC_MASK_PIN_BC    8'h9F

// Function select codes.
`define APC_FN_GPIO        2'h0
`define APC_FN_ALT1        2'h1
`define APC_FN_ALT2        2'h2
`define APC_FN_ALT3        2'h3

// Event status bit positions.
`define APC_EVT_RING       0
`define APC_EVT_EDGE1      1
`define APC_EVT_EDGE2      2

// Field position of the drive-0 force bit.
`define APC_BIT_FORCE_WP   0

// Timing figures.
`define APC_CLK_HZ         100000000
`define APC_RING_MIN_HZ    15
`define APC_RING_TRAIN_MS  200
`define APC_MS_PER_S       1000

`endif

//--- hw/apc_pkg.sv
/*
 * Types shared by the auxiliary pin block.
 * Assumes the map header is compiled alongside for constants.
 */
package apc_pkg;

    // One pin configuration byte.
    typedef struct packed {
        logic       open_drain;
        logic [1:0] rsvd;
        logic [1:0] func;
        logic       grp_en;
        logic       invert;
        logic       is_input;
    } apc_pin_cfg_t;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic       ds0_n;
        logic       wp_n;
        logic       pp_wp_n;
        logic       ri1_n;
        logic       ri2_n;
        logic [2:0] pin;
    } apc_pins_t;

endpackage

//--- hw/apc_top.sv
/*
 * Auxiliary pin block: forced write-protect, ring wake filter, three
 * configurable general-purpose pins and event latches, behind an APB slave.
 * Assumes one 100 MHz clock, a synchronous active-low reset, and that the
 * pin inputs are asynchronous to it while the watchdog, keyboard and
 * management interrupt sources run on the same clock.
 */
`timescale 1ns/1ps
`include "apc_map.svh"

module apc_top
    import apc_pkg::*;
#(
    parameter int ADDR_W         = 10,
    parameter int CNT_W          = 25,
    parameter int RING_GAP_CYC   = `APC_CLK_HZ / `APC_RING_MIN_HZ,
    parameter int RING_TRAIN_CYC = (`APC_CLK_HZ / `APC_MS_PER_S) * `APC_RING_TRAIN_MS
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Floppy write-protect path
    input  wire logic              DRIVE0_SELECT_N,
    input  wire logic              WRITE_PROTECT_N,
    input  wire logic              PP_WRITE_PROTECT_N,
    output logic                   CORE_WRITE_PROTECT_N,
    output logic                   PP_CORE_WRITE_PROTECT_N,
    // Ring inputs and wake outputs
    input  wire logic              RING_IND_PORT1_N,
    input  wire logic              RING_IND_PORT2_N,
    output logic                   RING_WAKE_OUT_N,
    output logic                   POWER_ON_REQ,
    // Alternate function sources
    input  wire logic              SYS_MGMT_IRQ_N,
    input  wire logic              WATCHDOG_OUT,
    input  wire logic              KBC_PORT1_BIT7,
    // General-purpose pins A, B, C
    input  wire logic [2:0]        PIN_IN,
    output logic      [2:0]        PIN_OUT,
    output logic      [2:0]        PIN_OE,
    // Interrupts
    output logic                   COMBINED_IRQ1,
    output logic                   EDGE_IRQ1,
    output logic                   EDGE_IRQ2
);

    localparam logic [CNT_W-1:0] GAP_MAX   = CNT_W'(RING_GAP_CYC);
    localparam logic [CNT_W-1:0] TRAIN_MAX = CNT_W'(RING_TRAIN_CYC - 1);

    apc_pins_t     sync1;
    apc_pins_t     sync2;
    logic [7:0]    force_wp;
    logic [7:0]    ring_sel;
    apc_pin_cfg_t  cfg [3];
    logic [2:0]    data_out;
    logic [2:0]    evt_latch;
    logic [2:0]    next_evt;
    logic [2:0]    in_val;
    logic [2:0]    in_prev;
    logic [2:0]    pin_src;
    logic [2:0]    ring_raw;
    logic [2:0]    ring_ind;
    logic          ring_any_q;
    logic [7:0]    idx;
    logic          aligned;
    logic          wr_acc;
    logic          rd_setup;
    logic          rd_acc;
    logic [31:0]   next_rdata;
    logic          next_err;
    logic [2:0]    edge_evt;

    // Every pin input passes two flops before anything reads it.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= {DRIVE0_SELECT_N, WRITE_PROTECT_N, PP_WRITE_PROTECT_N,
                      RING_IND_PORT1_N, RING_IND_PORT2_N, PIN_IN};
            sync2 <= sync1;
        end
    end

    assign idx      = PADDR[ADDR_W-1:2];
    assign aligned  = (PADDR[1:0] == 2'h0);
    assign wr_acc   = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_acc   = PSEL && PENABLE && PREADY && !PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;

    // Read data and error are formed in the setup cycle so they leave flops.
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (!aligned) begin
            next_err = 1'b1;
        end else if (idx == `APC_IDX_FORCE_WP) begin
            next_rdata[7:0] = force_wp & `APC_MASK_FORCE_WP;
        end else if (idx == `APC_IDX_RING_SEL) begin
            next_rdata[7:0] = ring_sel & `APC_MASK_RING_SEL;
        end else if (idx == `APC_IDX_PIN_A) begin
            next_rdata[7:0] = cfg[0] & `APC_MASK_PIN_A;
        end else if (idx == `APC_IDX_PIN_B) begin
            next_rdata[7:0] = cfg[1] & `APC_MASK_PIN_BC;
        end else if (idx == `APC_IDX_PIN_C) begin
            next_rdata[7:0] = cfg[2] & `APC_MASK_PIN_BC;
        end else if (idx == `APC_IDX_EVT_STAT) begin
            next_rdata[2:0] = evt_latch;
        end else if (idx == `APC_IDX_PIN_DATA) begin
            next_rdata[2:0] = in_val;
        end else begin
            next_err = 1'b1;
        end
    end

    // One-wait-free slave: ready rises for the access phase of each transfer.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && next_err;
            if (rd_setup) begin
                PRDATA <= next_rdata;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            force_wp <= `APC_RST_FORCE_WP;
            ring_sel <= `APC_RST_RING_SEL;
            data_out <= `APC_RST_PIN_DATA;
        end else if (wr_acc && aligned) begin
            if (idx == `APC_IDX_FORCE_WP) begin
                force_wp <= PWDATA[7:0] & `APC_MASK_FORCE_WP;
            end else if (idx == `APC_IDX_RING_SEL) begin
                ring_sel <= PWDATA[7:0] & `APC_MASK_RING_SEL;
            end else if (idx == `APC_IDX_PIN_DATA) begin
                data_out <= PWDATA[2:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cfg[0] <= `APC_RST_PIN_CFG;
            cfg[1] <= `APC_RST_PIN_CFG;
            cfg[2] <= `APC_RST_PIN_CFG;
        end else if (wr_acc && aligned) begin
            if (idx == `APC_IDX_PIN_A) begin
                cfg[0] <= PWDATA[7:0] & `APC_MASK_PIN_A;
            end else if (idx == `APC_IDX_PIN_B) begin
                cfg[1] <= PWDATA[7:0] & `APC_MASK_PIN_BC;
            end else if (idx == `APC_IDX_PIN_C) begin
                cfg[2] <= PWDATA[7:0] & `APC_MASK_PIN_BC;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CORE_WRITE_PROTECT_N    <= 1'b1;
            PP_CORE_WRITE_PROTECT_N <= 1'b1;
        end else begin
            CORE_WRITE_PROTECT_N    <= sync2.wp_n &&
                !(force_wp[`APC_BIT_FORCE_WP] && !sync2.ds0_n);
            PP_CORE_WRITE_PROTECT_N <= sync2.pp_wp_n &&
                !(force_wp[`APC_BIT_FORCE_WP] && !sync2.ds0_n);
        end
    end

    always_comb begin
        ring_raw[0] = (cfg[1].func == `APC_FN_ALT1) ? sync2.pin[1] : 1'b1;
        ring_raw[1] = sync2.ri1_n;
        ring_raw[2] = sync2.ri2_n;
    end

    // A train is qualified once falling edges keep arriving within one
    // slowest-rate period for the whole train time; a longer gap ends it.
    for (genvar ch = 0; ch < 3; ch++) begin : g_ring
        logic             prev;
        logic [CNT_W-1:0] gap;
        logic [CNT_W-1:0] train;
        logic             qual;

        always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
                prev  <= 1'b1;
                gap   <= GAP_MAX;
                train <= '0;
                qual  <= 1'b0;
            end else begin
                prev <= ring_raw[ch];
                if (prev && !ring_raw[ch]) begin
                    gap <= '0;
                end else if (gap != GAP_MAX) begin
                    gap <= gap + 1'b1;
                end
                if (gap == GAP_MAX) begin
                    train <= '0;
                    qual  <= 1'b0;
                end else if (train == TRAIN_MAX) begin
                    qual <= 1'b1;
                end else begin
                    train <= train + 1'b1;
                end
            end
        end

        assign ring_ind[ch] = ring_sel[ch] ? qual : !ring_raw[ch];
    end

    always_comb begin
        edge_evt    = 3'h0;
        edge_evt[`APC_EVT_RING]  = (|ring_ind) && !ring_any_q;
        edge_evt[`APC_EVT_EDGE1] = (cfg[1].func == `APC_FN_ALT2) &&
                                   (in_val[1] != in_prev[1]);
        edge_evt[`APC_EVT_EDGE2] = (cfg[2].func == `APC_FN_ALT3) &&
                                   (in_val[2] != in_prev[2]);
        // A read clears only the bits it reported in its setup cycle, so an
        // event landing between setup and access waits for the next read.
        // An edge in the clearing cycle itself survives as well.
        next_evt = evt_latch;
        if (rd_acc && aligned && idx == `APC_IDX_EVT_STAT) begin
            next_evt = evt_latch & ~PRDATA[2:0];
        end
        next_evt = next_evt | edge_evt;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ring_any_q      <= 1'b0;
            in_prev         <= 3'h0;
            evt_latch       <= 3'h0;
            RING_WAKE_OUT_N <= 1'b1;
            POWER_ON_REQ    <= 1'b0;
            EDGE_IRQ1       <= 1'b0;
            EDGE_IRQ2       <= 1'b0;
        end else begin
            ring_any_q      <= |ring_ind;
            in_prev         <= in_val;
            evt_latch       <= next_evt;
            RING_WAKE_OUT_N <= !(|ring_ind);
            POWER_ON_REQ    <= next_evt[`APC_EVT_RING];
            EDGE_IRQ1       <= next_evt[`APC_EVT_EDGE1];
            EDGE_IRQ2       <= next_evt[`APC_EVT_EDGE2];
        end
    end

    always_comb begin
        pin_src[0] = cfg[0].func[0] ? SYS_MGMT_IRQ_N : data_out[0];
        pin_src[1] = data_out[1];
        case (cfg[2].func)
            `APC_FN_ALT1: pin_src[2] = WATCHDOG_OUT;
            `APC_FN_ALT2: pin_src[2] = KBC_PORT1_BIT7;
            default:      pin_src[2] = data_out[2];
        endcase
    end

    for (genvar p = 0; p < 3; p++) begin : g_pin
        assign in_val[p] = sync2.pin[p] ^ cfg[p].invert;

        always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
                PIN_OUT[p] <= 1'b0;
                PIN_OE[p]  <= 1'b0;
            end else begin
                if (cfg[p].is_input) begin
                    PIN_OUT[p] <= 1'b0;
                    PIN_OE[p]  <= 1'b0;
                end else if (cfg[p].open_drain) begin
                    PIN_OUT[p] <= 1'b0;
                    PIN_OE[p]  <= !(pin_src[p] ^ cfg[p].invert);
                end else begin
                    PIN_OUT[p] <= pin_src[p] ^ cfg[p].invert;
                    PIN_OE[p]  <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            COMBINED_IRQ1 <= 1'b0;
        end else begin
            COMBINED_IRQ1 <= |(in_val & {cfg[2].grp_en, cfg[1].grp_en, cfg[0].grp_en});
        end
    end

endmodule

//--- bench/apc_top_asserts.sv
/*
 * Port checker for apc_top, bound to every instance of it.
 * Assumes one clock, a synchronous active-low reset and index 0xF0 at byte 0x3C0.
 */
`timescale 1ns/1ps

module apc_top_asserts #(
    parameter int ADDR_W = 10
) (
    // Clock, reset and APB
    input wire logic              SYS_CLK,
    input wire logic              RST_N,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // Write-protect path
    input wire logic              WRITE_PROTECT_N,
    input wire logic              PP_WRITE_PROTECT_N,
    input wire logic              CORE_WRITE_PROTECT_N,
    input wire logic              PP_CORE_WRITE_PROTECT_N,
    // Wake, events and pins
    input wire logic              RING_WAKE_OUT_N,
    input wire logic              POWER_ON_REQ,
    input wire logic              EDGE_IRQ1,
    input wire logic [2:0]        PIN_OE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic rd_stat;
    // Only a completed read of the status word may clear a latch.
    assign rd_stat = PSEL && PENABLE && PREADY && !PWRITE && PADDR == 10'h3C0;
    property p_ready;
        PSEL && !PENABLE |=> PREADY ##1 !PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
    property p_err;
        PSLVERR |-> PREADY;
    endproperty
    a_err: assert property (p_err) else $error("error outside access cycle");
    property p_wp;
        !WRITE_PROTECT_N [*4] |-> !CORE_WRITE_PROTECT_N;
    endproperty
    a_wp: assert property (p_wp) else $error("drive write-protect not passed");
    property p_pp_wp;
        !PP_WRITE_PROTECT_N [*4] |-> !PP_CORE_WRITE_PROTECT_N;
    endproperty
    a_pp_wp: assert property (p_pp_wp) else $error("port write-protect not passed");
    property p_rst;
        $rose(RST_N) |-> PIN_OE == 3'h0 && RING_WAKE_OUT_N && !POWER_ON_REQ;
    endproperty
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
    property p_ring_set;
        $fell(RING_WAKE_OUT_N) |-> ##[0:2] POWER_ON_REQ;
    endproperty
    a_ring_set: assert property (p_ring_set) else $error("ring did not latch");
    property p_ring_hold;
        POWER_ON_REQ && !rd_stat |=> POWER_ON_REQ;
    endproperty
    a_ring_hold: assert property (p_ring_hold) else $error("ring latch lost");
    property p_edge_hold;
        EDGE_IRQ1 && !rd_stat |=> EDGE_IRQ1;
    endproperty
    a_edge_hold: assert property (p_edge_hold) else $error("edge latch lost");
    c_ring: cover property ($rose(POWER_ON_REQ));
    c_edge: cover property ($rose(EDGE_IRQ1));
    c_err: cover property (PSLVERR);
endmodule

bind apc_top apc_top_asserts #(.ADDR_W(ADDR_W)) apc_top_asserts_inst (.*);

//--- bench/apc_far_side.sv
/*
 * Far-side model: modem ring lines and the board around pins A to C.
 * Assumes the bench changes its controls just after a rising edge.
 */
`timescale 1ns/1ps

module apc_far_side #(
    parameter int HALF = 10
) (
    // Clock
    input wire logic       clk,
    // Bench controls
    input wire logic [2:0] ring_on,
    input wire logic [2:0] ext_val,
    // Block side
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    output logic     [2:0] pin_in,
    output logic           ri1_n,
    output logic           ri2_n
);
    int   cnt;
    logic tog;
    always_ff @(posedge clk) begin
        if (ring_on == 3'h0) begin
            cnt <= 0;
            tog <= 1'b1;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            tog <= !tog;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Ring lines are pulled up, so a quiet line rests high.
    assign ri1_n = ring_on[1] ? tog : 1'b1;
    assign ri2_n = ring_on[2] ? tog : 1'b1;
    // A released pin shows the board level; ring source 0 rides on pin B.
    always_comb begin
        pin_in = ext_val;
        if (ring_on[0]) begin
            pin_in[1] = tog;
        end
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end
        end
    end
endmodule

//--- bench/tb_apc_top.sv
/*
 * Self-checking bench for apc_top over APB with the far-side model.
 * Assumes the checker and the model are compiled before it.
 */
`timescale 1ns/1ps

module tb_apc_top;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, ds0_n = 1'b1, wp_n = 1'b1, pp_wp_n = 1'b1;
    logic        smi_n = 1'b1, wdog = 1'b0, kbc = 1'b0, core_wp_n, pp_core_wp_n;
    logic        ri1_n, ri2_n, wake_n, pwr_on, cirq, eirq1, eirq2;
    logic [2:0]  pin_in, pin_out, pin_oe, ring_on = 3'h0, ext = 3'h7;
    logic [7:0]  idx_t[5] = '{8'hC5, 8'hC6, 8'hE0, 8'hE1, 8'hE2};
    logic [7:0]  rst_t[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
    int          n_errors = 0, checks = 0;

    initial forever #5 clk = !clk;

    apc_top #(.RING_GAP_CYC(40), .RING_TRAIN_CYC(200)) apc_top_inst (
        .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DRIVE0_SELECT_N(ds0_n), .WRITE_PROTECT_N(wp_n),
        .PP_WRITE_PROTECT_N(pp_wp_n), .CORE_WRITE_PROTECT_N(core_wp_n),
        .PP_CORE_WRITE_PROTECT_N(pp_core_wp_n), .RING_IND_PORT1_N(ri1_n),
        .RING_IND_PORT2_N(ri2_n), .RING_WAKE_OUT_N(wake_n), .POWER_ON_REQ(pwr_on),
        .SYS_MGMT_IRQ_N(smi_n), .WATCHDOG_OUT(wdog), .KBC_PORT1_BIT7(kbc),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .COMBINED_IRQ1(cirq),
        .EDGE_IRQ1(eirq1), .EDGE_IRQ2(eirq2));
    apc_far_side #(.HALF(10)) apc_far_side_inst (.clk(clk), .ring_on(ring_on),
        .ext_val(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ri1_n(ri1_n), .ri2_n(ri2_n));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the answer is taken at the edge that sees ready high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic w(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic r(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, exp, rd);
    endtask
    task automatic pin(input logic [7:0] idx, cfg, input int p, input logic [1:0] e);
        w(idx, cfg);
        tick(2);
        chk("pin drive", {30'h0, e}, {30'h0, pin_oe[p], pin_out[p]});
    endtask
    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        n_errors++;
        end_sim();
    end

    initial begin
        tick(4);
        rst_n <= 1'b1;
        tick(2);
        foreach (idx_t[i]) r("reset value", idx_t[i], {24'h0, rst_t[i]});
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, err});
        w(8'hC5, 8'hFF);
        r("force reserved", 8'hC5, 32'h01);
        w(8'hC6, 8'hFF);
        r("ring select", 8'hC6, 32'h07);
        ds0_n <= 1'b0;
        tick(5);
        chk("core wp forced", 32'h0, {31'h0, core_wp_n});
        chk("port wp forced", 32'h0, {31'h0, pp_core_wp_n});
        ds0_n <= 1'b1;
        tick(5);
        chk("core wp deselected", 32'h1, {31'h0, core_wp_n});
        w(8'hC5, 8'h00);
        w(8'hC6, 8'h00);
        wp_n <= 1'b0;
        pp_wp_n <= 1'b0;
        tick(5);
        chk("core wp passed", 32'h0, {31'h0, core_wp_n});
        chk("port wp passed", 32'h0, {31'h0, pp_core_wp_n});
        wp_n <= 1'b1;
        pp_wp_n <= 1'b1;
        ring_on <= 3'h2;
        tick(17);
        chk("ring plain edge", 32'h0, {31'h0, wake_n});
        chk("power on", 32'h1, {31'h0, pwr_on});
        ring_on <= 3'h0;
        tick(5);
        r("ring latch", 8'hF0, 32'h1);
        r("latch cleared", 8'hF0, 32'h0);
        w(8'hE1, 8'h09);
        for (int ch = 0; ch < 3; ch++) begin
            w(8'hC6, 8'h01 << ch);
            ring_on <= 3'h1 << ch;
            tick(100);
            chk("ring early", 32'h1, {31'h0, wake_n});
            tick(200);
            chk("ring train", 32'h0, {31'h0, wake_n});
            tick(150);
            chk("ring held", 32'h0, {31'h0, wake_n});
            ring_on <= 3'h0;
            tick(60);
            chk("ring stop", 32'h1, {31'h0, wake_n});
            apb(1'b0, 8'hF0, 8'h00);
        end
        w(8'hF1, 8'h01);
        pin(8'hE0, 8'h00, 0, 2'b11);
        pin(8'hE0, 8'h02, 0, 2'b10);
        pin(8'hE0, 8'h80, 0, 2'b00);
        pin(8'hE0, 8'h82, 0, 2'b10);
        pin(8'hE0, 8'h01, 0, 2'b00);
        smi_n <= 1'b0;
        pin(8'hE0, 8'h08, 0, 2'b10);
        smi_n <= 1'b1;
        pin(8'hE0, 8'h08, 0, 2'b11);
        wdog <= 1'b1;
        pin(8'hE2, 8'h08, 2, 2'b11);
        pin(8'hE2, 8'h10, 2, 2'b10);
        pin(8'hE2, 8'h00, 2, 2'b10);
        w(8'hE0, 8'h05);
        tick(5);
        chk("group irq", 32'h1, {31'h0, cirq});
        ext <= 3'h6;
        tick(5);
        chk("group irq level", 32'h0, {31'h0, cirq});
        ext <= 3'h7;
        w(8'hE0, 8'h01);
        tick(5);
        chk("group masked", 32'h0, {31'h0, cirq});
        w(8'hE0, 8'h03);
        tick(5);
        r("pin data", 8'hF1, 32'h2);
        w(8'hE1, 8'h11);
        ext <= 3'h5;
        tick(6);
        chk("edge one fall", 32'h1, {31'h0, eirq1});
        r("edge one latch", 8'hF0, 32'h2);
        ext <= 3'h7;
        tick(6);
        chk("edge one rise", 32'h1, {31'h0, eirq1});
        apb(1'b0, 8'hF0, 8'h00);
        chk("edge one cleared", 32'h0, {31'h0, eirq1});
        ext <= 3'h3;
        w(8'hE2, 8'h19);
        tick(6);
        ext <= 3'h7;
        tick(6);
        chk("edge two", 32'h1, {31'h0, eirq2});
        r("edge two latch", 8'hF0, 32'h4);
        end_sim();
    end
endmodule
